// ==== core/lif_config_bank.sv ====
`include "lif_params.svh"
`default_nettype none
module lif_config_bank (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive line observations, one lane per link
    input wire logic [7:0] pulse_tick,
    input wire logic [7:0] level_low,
    input wire logic [6:0] ptr_distance [8],
    // per-link controls and status
    output lif_pkg::lif_tx_ctl_type tx_ctl [8],
    output lif_pkg::lif_rx_ctl_type rx_ctl [8],
    output lif_pkg::lif_ja_ctl_type ja_ctl [8],
    output logic [7:0] signal_lost,
    // template waveform read port for the line driver
    input wire logic [5:0] wave_addr [8],
    output logic [6:0] wave_word [8]
);
    import lif_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [2:0] link;
    logic [7:0] ofs;
    logic mapped;
    logic wr;
    logic [7:0] wdat;
    // one index step per word; the top index bit is unmapped
    assign link = paddr[12:10];
    assign ofs = paddr[9:2];
    assign wdat = pwdata[7:0];
    assign pready = 1'b1;
    always_comb begin
        case (ofs)
            `LIF_OFS_TSEL, `LIF_OFS_AMP, `LIF_OFS_ACC,
            `LIF_OFS_DATA, `LIF_OFS_JA, `LIF_OFS_RX0,
            `LIF_OFS_RX1, `LIF_OFS_RX2, `LIF_OFS_MNT,
            `LIF_OFS_JST: mapped = !paddr[13];
            default: mapped = 1'b0;
        endcase
    end
    assign wr = psel && penable && pwrite && mapped;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] tsel [8];
    logic [7:0] amp [8];
    logic [7:0] acc [8];
    logic [7:0] tdat [8];
    logic [7:0] jacfg [8];
    logic [7:0] rx0 [8];
    logic [7:0] rx1 [8];
    logic [7:0] rx2 [8];
    logic [7:0] mnt [8];
    logic [6:0] jstat [8];
    logic [6:0] tram [8][64];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                tsel[i] <= `LIF_RST_ZERO;
                amp[i] <= `LIF_RST_AMP;
                acc[i] <= `LIF_RST_ZERO;
                jacfg[i] <= `LIF_RST_ZERO;
                rx0[i] <= `LIF_RST_ZERO;
                rx1[i] <= `LIF_RST_RX1;
                rx2[i] <= `LIF_RST_RX2;
                mnt[i] <= `LIF_RST_ZERO;
            end
        end else if (wr) begin
            case (ofs)
                `LIF_OFS_TSEL: tsel[link] <= wdat & `LIF_MSK_TSEL;
                `LIF_OFS_AMP: amp[link] <= wdat & `LIF_MSK_AMP;
                `LIF_OFS_ACC: acc[link] <= wdat & `LIF_MSK_ACC;
                `LIF_OFS_JA: jacfg[link] <= wdat & `LIF_MSK_JA;
                `LIF_OFS_RX0: rx0[link] <= wdat & `LIF_MSK_RX0;
                `LIF_OFS_RX1: rx1[link] <= wdat & `LIF_MSK_RX1;
                `LIF_OFS_RX2: rx2[link] <= wdat & `LIF_MSK_RX2;
                `LIF_OFS_MNT: mnt[link] <= wdat & `LIF_MSK_MNT;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // template ram access
    // ------------------------------------------------------------
    logic acc_wr;
    logic arb_sel;
    logic ram_we;
    logic ram_re;
    logic [5:0] ram_addr;
    logic [6:0] ram_q;
    assign acc_wr = wr && (ofs == `LIF_OFS_ACC);
    assign arb_sel = (tsel[link][3:2] == 2'b11);
    assign ram_addr = wdat[5:0];
    assign ram_q = tram[link][ram_addr];
    assign ram_we = acc_wr && arb_sel && wdat[`LIF_ACC_EN]
        && !wdat[`LIF_ACC_RD];
    assign ram_re = acc_wr && arb_sel && wdat[`LIF_ACC_EN]
        && wdat[`LIF_ACC_RD];

    // ram content is not reset: software loads it before use
    always_ff @(posedge pclk) begin
        if (ram_we) begin
            tram[link][ram_addr] <= tdat[link][6:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                tdat[i] <= `LIF_RST_ZERO;
            end
        end else if (wr && ofs == `LIF_OFS_DATA) begin
            tdat[link] <= wdat & `LIF_MSK_DATA;
        end else if (ram_re) begin
            tdat[link] <= {1'b0, ram_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                wave_word[i] <= 7'h00;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                wave_word[i] <= tram[i][wave_addr[i]];
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = psel && penable && !mapped;
        if (psel && !pwrite && mapped) begin
            case (ofs)
                `LIF_OFS_TSEL: prdata[7:0] = tsel[link];
                `LIF_OFS_AMP: prdata[7:0] = amp[link];
                `LIF_OFS_ACC: prdata[7:0] = acc[link];
                `LIF_OFS_DATA: prdata[7:0] = tdat[link];
                `LIF_OFS_JA: prdata[7:0] = jacfg[link];
                `LIF_OFS_RX0: prdata[7:0] = rx0[link];
                `LIF_OFS_RX1: prdata[7:0] = rx1[link];
                `LIF_OFS_RX2: prdata[7:0] = rx2[link];
                `LIF_OFS_MNT: prdata[7:0] = mnt[link];
                `LIF_OFS_JST: prdata[6:0] = jstat[link];
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // per-link line logic
    // ------------------------------------------------------------
    logic [10:0] low_cnt [8];
    logic [10:0] los_n [8];

    for (genvar g = 0; g < 8; g++) begin : g_link
        logic [6:0] depth;
        logic [6:0] margin;
        logic near_edge;
        always_comb begin
            case (jacfg[g][2:1])
                2'b00: depth = 7'h7F;
                2'b01: depth = 7'h40;
                default: depth = 7'h20;
            endcase
            case (jacfg[g][2:1])
                2'b00: margin = 7'h04;
                2'b01: margin = 7'h03;
                default: margin = 7'h02;
            endcase
        end
        // 128 does not fit seven bits; top of range is 127
        assign near_edge = (ptr_distance[g] <= margin)
            || (ptr_distance[g] >= depth - margin);

        always_comb begin
            tx_ctl[g].step = amp[g][5:0];
            tx_ctl[g].template_sel = tsel[g][3:0];
            case (tsel[g][3:0])
                4'hB: tx_ctl[g].nominal = `LIF_NOM_LH22;
                4'hA: tx_ctl[g].nominal = `LIF_NOM_LH15;
                4'h9: tx_ctl[g].nominal = `LIF_NOM_LH7;
                default: tx_ctl[g].nominal = `LIF_NOM_SH;
            endcase
            rx_ctl[g].power_down = rx0[g][`LIF_RX0_PD];
            rx_ctl[g].decode_ami = rx0[g][`LIF_RX0_AMI];
            rx_ctl[g].equalizer_enable = rx1[g][`LIF_RX1_EQ];
            rx_ctl[g].los_q = rx1[g][`LIF_RX1_EQ] ? rx1[g][4:0] : 5'h00;
            rx_ctl[g].slice = rx2[g][5:4];
            rx_ctl[g].window_bits = 9'h020 << rx2[g][3:2];
            ja_ctl[g].enable = jacfg[g][`LIF_JA_EN];
            ja_ctl[g].wide_track = jacfg[g][`LIF_JA_EN]
                && jacfg[g][`LIF_JA_WIDE] && near_edge;
            ja_ctl[g].bw_low = jacfg[g][`LIF_JA_BW];
            // 127 stands in for the 128-bit fifo; report the true depth
            ja_ctl[g].depth_bits = (depth == 7'h7F) ? 8'h80 : {1'b0, depth};
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                jstat[g] <= 7'h00;
            end else if (!jacfg[g][`LIF_JA_MON]) begin
                jstat[g] <= ptr_distance[g];
            end else if (ptr_distance[g] > jstat[g]) begin
                jstat[g] <= ptr_distance[g];
            end
        end

        assign los_n[g] = mnt[g][`LIF_MNT_LAC] ? `LIF_LOS_N_ALT
            : `LIF_LOS_N_FIRST;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                low_cnt[g] <= 11'h000;
            end else if (pulse_tick[g]) begin
                if (!level_low[g]) begin
                    low_cnt[g] <= 11'h000;
                end else if (low_cnt[g] < los_n[g]) begin
                    low_cnt[g] <= low_cnt[g] + 11'h001;
                end
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                signal_lost[g] <= 1'b0;
            end else begin
                signal_lost[g] <= (low_cnt[g] >= los_n[g]);
            end
        end

        // per-link checks: every lane, so a random test link is covered
        depth_code_a: assert property (@(posedge pclk) disable iff (!presetn)
            jacfg[g][2:1] == 2'b01 |-> ja_ctl[g].depth_bits == 8'h40)
            else $error("depth code not decoded");
        window_len_a: assert property (@(posedge pclk) disable iff (!presetn)
            rx2[g][3:2] == 2'b11 |-> rx_ctl[g].window_bits == 9'h100)
            else $error("peak window length wrong");
        sh_nominal_a: assert property (@(posedge pclk) disable iff (!presetn)
            tsel[g][3:0] == 4'h8 |-> tx_ctl[g].nominal == `LIF_NOM_SH)
            else $error("short haul nominal wrong");
        rx_off_a: assert property (@(posedge pclk) disable iff (!presetn)
            rx0[g][`LIF_RX0_PD] |-> rx_ctl[g].power_down)
            else $error("receive path not powered down");
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    tmpl_write_a: assert property (ram_we |-> acc_wr && arb_sel
        && wdat[`LIF_ACC_EN] && !wdat[`LIF_ACC_RD])
        else $error("template write without enable");
    tmpl_dir_a: assert property (ram_re |-> !ram_we)
        else $error("read and write together");
    sel_gate_a: assert property (acc_wr && !arb_sel
        |=> $stable(tdat[$past(link)]))
        else $error("template access outside 11xx");
    read_back_a: assert property (ram_re
        |=> tdat[$past(link)][6:0] == $past(ram_q))
        else $error("template read not returned");
    live_dist_a: assert property (!jacfg[0][`LIF_JA_MON]
        |=> jstat[0] == $past(ptr_distance[0]))
        else $error("live distance not shown");
    peak_hold_a: assert property (jacfg[0][`LIF_JA_MON]
        && $past(jacfg[0][`LIF_JA_MON]) |-> jstat[0] >= $past(jstat[0]))
        else $error("peak distance dropped");
    wide_off_a: assert property (!jacfg[0][`LIF_JA_EN]
        |-> !ja_ctl[0].wide_track && !ja_ctl[0].enable)
        else $error("attenuator active while disabled");
    wide_cond_a: assert property (ja_ctl[0].wide_track
        |-> jacfg[0][`LIF_JA_WIDE])
        else $error("widening without option");
    los_rise_a: assert property ($rose(signal_lost[0])
        |-> $past(low_cnt[0]) >= $past(los_n[0]))
        else $error("loss declared early");
    los_sat_a: assert property (low_cnt[0] <= `LIF_LOS_N_ALT)
        else $error("interval count beyond limit");
    // a count left high by the other criterion may stand above the limit
    los_first_a: assert property (!mnt[0][`LIF_MNT_LAC]
        && $past(!mnt[0][`LIF_MNT_LAC])
        && $past(low_cnt[0]) <= `LIF_LOS_N_FIRST
        |-> low_cnt[0] <= `LIF_LOS_N_FIRST)
        else $error("first criterion count beyond limit");
    short_q_a: assert property (!rx_ctl[0].equalizer_enable
        |-> rx_ctl[0].los_q == 5'h00)
        else $error("threshold used in short haul");
    unmapped_a: assert property (pslverr |-> prdata == 32'h0000_0000)
        else $error("unmapped access returned data");

    tmpl_wr_c: cover property (ram_we);
    tmpl_rd_c: cover property (ram_re ##1 psel && !pwrite
        && ofs == `LIF_OFS_DATA);
    los_c: cover property ($rose(signal_lost[0]));
    wide_c: cover property (ja_ctl[0].wide_track);
    peak_c: cover property (jacfg[0][`LIF_JA_MON] && ptr_distance[0] > jstat[0]);
endmodule : lif_config_bank
`default_nettype wire

// ==== common/lif_params.svh ====
`ifndef LIF_PARAMS_SVH
`define LIF_PARAMS_SVH
// ----------------------------------------------------------------
// register indices inside one link (byte address is four times)
// ----------------------------------------------------------------
`define LIF_OFS_TSEL 8'h23
`define LIF_OFS_AMP 8'h24
`define LIF_OFS_ACC 8'h25
`define LIF_OFS_DATA 8'h26
`define LIF_OFS_JA 8'h27
`define LIF_OFS_RX0 8'h28
`define LIF_OFS_RX1 8'h29
`define LIF_OFS_RX2 8'h2A
`define LIF_OFS_MNT 8'h2C
`define LIF_OFS_JST 8'h39
// ----------------------------------------------------------------
// writable bits per register
// ----------------------------------------------------------------
`define LIF_MSK_TSEL 8'h0F
`define LIF_MSK_AMP 8'h3F
`define LIF_MSK_ACC 8'hFF
`define LIF_MSK_DATA 8'h7F
`define LIF_MSK_JA 8'h3F
`define LIF_MSK_RX0 8'h11
`define LIF_MSK_RX1 8'h5F
`define LIF_MSK_RX2 8'h3F
`define LIF_MSK_MNT 8'h10
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LIF_RST_ZERO 8'h00
`define LIF_RST_AMP 8'h21
`define LIF_RST_RX1 8'h15
`define LIF_RST_RX2 8'h18
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LIF_ACC_EN 7
`define LIF_ACC_RD 6
`define LIF_JA_MON 5
`define LIF_JA_WIDE 4
`define LIF_JA_EN 3
`define LIF_JA_BW 0
`define LIF_RX0_PD 4
`define LIF_RX0_AMI 0
`define LIF_RX1_EQ 6
`define LIF_MNT_LAC 4
// ----------------------------------------------------------------
// counts and codes
// ----------------------------------------------------------------
`define LIF_LOS_N_FIRST 11'd175
`define LIF_LOS_N_ALT 11'd1544
`define LIF_NOM_LH22 6'h04
`define LIF_NOM_LH15 6'h08
`define LIF_NOM_LH7 6'h11
`define LIF_NOM_SH 6'h36
`endif

// ==== common/lif_pkg.sv ====
`default_nettype none
package lif_pkg;
    // receive path controls for one link
    typedef struct packed {
        logic power_down;
        logic decode_ami;
        logic equalizer_enable;
        logic [4:0] los_q;
        logic [1:0] slice;
        logic [8:0] window_bits;
    } lif_rx_ctl_type;
    // receive jitter attenuator controls for one link
    typedef struct packed {
        logic enable;
        logic wide_track;
        logic bw_low;
        logic [7:0] depth_bits;
    } lif_ja_ctl_type;
    // transmit amplitude controls for one link
    typedef struct packed {
        logic [5:0] step;
        logic [5:0] nominal;
        logic [3:0] template_sel;
    } lif_tx_ctl_type;
endpackage : lif_pkg
`default_nettype wire

// ==== bench/lif_line_model.sv ====
`default_nettype none
module lif_line_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // commands from the bench
    input wire logic [7:0] low_cmd,
    input wire logic [6:0] dist_cmd [8],
    // line observations
    output logic [7:0] pulse_tick,
    output logic [7:0] level_low,
    output logic [6:0] ptr_distance [8]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] gap;

    // one pulse interval every four clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 2'h0;
        end else begin
            gap <= gap + 2'h1;
        end
    end

    // level only means something on a tick, so it lies in between
    assign pulse_tick = (gap == 2'h3) ? 8'hFF : 8'h00;
    assign level_low = (gap == 2'h3) ? low_cmd : ~low_cmd;
    assign ptr_distance = dist_cmd;
endmodule : lif_line_model
`default_nettype wire

// ==== bench/test_line_interface_config_bank.sv ====
`include "lif_params.svh"
`default_nettype none
module test_line_interface_config_bank;
    import lif_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] pulse_tick, level_low, low_cmd, signal_lost;
    logic [6:0] ptr_distance [8];
    logic [6:0] dist_cmd [8];
    logic [5:0] wave_addr [8];
    logic [6:0] wave_word [8];
    lif_tx_ctl_type tx_ctl [8];
    lif_rx_ctl_type rx_ctl [8];
    lif_ja_ctl_type ja_ctl [8];
    logic [32:0] exp_q [$];
    logic [32:0] nx;
    int err_total, cmp_count;
    logic [3:0] sel_t [6] = '{4'hB, 4'hA, 4'h9, 4'h8, 4'h7, 4'h2};
    logic [5:0] nom_t [6] = '{6'h04, 6'h08, 6'h11, 6'h36, 6'h36, 6'h36};

    lif_config_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_tick(pulse_tick),
        .level_low(level_low), .ptr_distance(ptr_distance),
        .tx_ctl(tx_ctl), .rx_ctl(rx_ctl), .ja_ctl(ja_ctl),
        .signal_lost(signal_lost), .wave_addr(wave_addr),
        .wave_word(wave_word));
    lif_line_model u_line (.pclk(pclk), .presetn(presetn),
        .low_cmd(low_cmd), .dist_cmd(dist_cmd), .pulse_tick(pulse_tick),
        .level_low(level_low), .ptr_distance(ptr_distance));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [13:0] adr(input int l, input logic [7:0] i);
        return {1'b0, 3'(l), i, 2'b00};
    endfunction : adr
    // request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [13:0] a,
            input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic wr(input int l, input logic [7:0] i, d);
        xfer(1'b1, adr(l, i), d);
    endtask : wr
    task automatic rd(input int l, input logic [7:0] i, d);
        exp_q.push_back({1'b0, 24'h0, d});
        xfer(1'b0, adr(l, i), 8'h00);
    endtask : rd
    task automatic wave(input int l, input logic [5:0] a, input logic [6:0] w);
        wave_addr[l] <= a;
        @(posedge pclk);
        @(negedge pclk);
        chk("wave_word", {25'h0, w}, {25'h0, wave_word[l]});
        @(posedge pclk);
    endtask : wave
    task automatic summarize;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // clock, watchdog, read monitor
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        summarize();
    end
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
            end else begin
                nx = exp_q.pop_front();
                chk("pslverr", {31'h0, nx[32]}, {31'h0, pslverr});
                chk("prdata", nx[31:0], prdata);
            end
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin : main
        int l, m, dp, d, n;
        logic [6:0] w;
        logic [5:0] a;
        {presetn, psel, penable, pwrite, paddr, pwdata, low_cmd} = '0;
        foreach (dist_cmd[k]) dist_cmd[k] = 7'h00;
        foreach (wave_addr[k]) wave_addr[k] = 6'h00;
        void'($urandom(32'h0d0013bf));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 8; k += 7) begin
            rd(k, `LIF_OFS_TSEL, 8'h00);
            rd(k, `LIF_OFS_AMP, 8'h21);
            rd(k, `LIF_OFS_ACC, 8'h00);
            rd(k, `LIF_OFS_JA, 8'h00);
            rd(k, `LIF_OFS_RX0, 8'h00);
            rd(k, `LIF_OFS_RX1, 8'h15);
            rd(k, `LIF_OFS_RX2, 8'h18);
        end
        l = 1 + ($urandom % 7);
        wr(l, `LIF_OFS_AMP, 8'h36);
        rd(l, `LIF_OFS_AMP, 8'h36);
        rd(l - 1, `LIF_OFS_AMP, 8'h21);
        exp_q.push_back({1'b1, 32'h0});
        xfer(1'b0, adr(l, 8'h10), 8'h00);
        exp_q.push_back({1'b1, 32'h0});
        xfer(1'b0, adr(l, `LIF_OFS_AMP) | 14'h2000, 8'h00);
        foreach (sel_t[k]) begin
            wr(l, `LIF_OFS_TSEL, {4'h0, sel_t[k]});
            @(negedge pclk);
            chk("nominal", {26'h0, nom_t[k]}, {26'h0, tx_ctl[l].nominal});
            chk("step", 32'h36, {26'h0, tx_ctl[l].step});
            chk("tsel", {28'h0, sel_t[k]}, {28'h0, tx_ctl[l].template_sel});
            @(posedge pclk);
        end
        for (int c = 0; c < 4; c++) begin
            m = (c == 0) ? 4 : (c == 1) ? 3 : 2;
            dp = (c == 0) ? 127 : (c == 1) ? 64 : 32;
            wr(l, `LIF_OFS_JA, 8'h18 | 8'(c << 1) | 8'(c & 1));
            for (int j = 0; j < 4; j++) begin
                d = (j < 2) ? m + j : dp - m - (j - 2);
                dist_cmd[l] <= 7'(d);
                @(negedge pclk);
                chk("depth", 32'(128 >> ((c > 2) ? 2 : c)), ja_ctl[l].depth_bits);
                chk("bw_low", 32'(c & 1), ja_ctl[l].bw_low);
                chk("enable", 32'h1, ja_ctl[l].enable);
                chk("wide", (d <= m) || (d >= dp - m), ja_ctl[l].wide_track);
                @(posedge pclk);
            end
        end
        wr(l, `LIF_OFS_JA, 8'h10);
        @(negedge pclk);
        chk("enable", 32'h0, ja_ctl[l].enable);
        chk("wide", 32'h0, ja_ctl[l].wide_track);
        @(posedge pclk);
        w = 7'($urandom % 64);
        dist_cmd[l] <= w;
        repeat (2) @(posedge pclk);
        rd(l, `LIF_OFS_JST, {1'b0, w});
        wr(l, `LIF_OFS_JA, 8'h20);
        dist_cmd[l] <= w + 7'h40;
        repeat (2) @(posedge pclk);
        dist_cmd[l] <= w;
        repeat (2) @(posedge pclk);
        rd(l, `LIF_OFS_JST, {1'b0, w + 7'h40});
        for (int k = 0; k < 4; k++) begin
            a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($urandom);
            w = 7'($urandom);
            wr(l, `LIF_OFS_TSEL, 8'h0C + 8'(k));
            wr(l, `LIF_OFS_DATA, {1'b0, w});
            wr(l, `LIF_OFS_ACC, {2'b10, a});
            wave(l, a, w);
            wr(l, `LIF_OFS_DATA, {1'b0, ~w});
            wr(l, `LIF_OFS_ACC, {2'b11, a});
            rd(l, `LIF_OFS_DATA, {1'b0, w});
            wr(l, `LIF_OFS_DATA, {1'b0, ~w});
            wr(l, `LIF_OFS_ACC, {2'b00, a});
            wave(l, a, w);
            wr(l, `LIF_OFS_TSEL, 8'h08);
            wr(l, `LIF_OFS_ACC, {2'b10, a});
            wave(l, a, w);
        end
        wr(l, `LIF_OFS_DATA, 8'hFF);
        rd(l, `LIF_OFS_DATA, 8'h7F);
        for (int p = 0; p < 2; p++) begin
            wr(l, `LIF_OFS_RX0, p ? 8'h11 : 8'h00);
            wr(l, `LIF_OFS_RX1, {1'b0, 1'(p), 6'h0A});
            @(negedge pclk);
            chk("power_down", 32'(p), rx_ctl[l].power_down);
            chk("decode_ami", 32'(p), rx_ctl[l].decode_ami);
            chk("equalizer_enable", 32'(p), rx_ctl[l].equalizer_enable);
            chk("los_q", p ? 32'h0A : 32'h0, rx_ctl[l].los_q);
            @(posedge pclk);
        end
        for (int c = 0; c < 4; c++) begin
            wr(l, `LIF_OFS_RX2, 8'(c << 4) | 8'(c << 2));
            @(negedge pclk);
            chk("slice", 32'(c), rx_ctl[l].slice);
            chk("window", 32'(32 << c), rx_ctl[l].window_bits);
            @(posedge pclk);
        end
        for (int c = 0; c < 2; c++) begin
            n = c ? 1544 : 175;
            wr(l, `LIF_OFS_MNT, 8'(c << 4));
            @(posedge pclk iff pulse_tick[l]);
            low_cmd[l] <= 1'b1;
            repeat (n - 1) @(posedge pclk iff pulse_tick[l]);
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk("signal_lost", 32'h0, signal_lost[l]);
            @(posedge pclk iff pulse_tick[l]);
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk("signal_lost", 32'h1, signal_lost[l]);
            @(posedge pclk);
            low_cmd[l] <= 1'b0;
            @(posedge pclk iff pulse_tick[l]);
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk("signal_lost", 32'h0, signal_lost[l]);
            @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
        if (exp_q.size() != 0) err_total++;
        summarize();
    end
endmodule : test_line_interface_config_bank
`default_nettype wire
